// [vsc_pkg.sv]
`default_nettype none

package vsc_pkg;

   // ---------------------------------------------------------------
   // command header encodings
   // ---------------------------------------------------------------
   localparam logic [2:0] CMD_TYPE      = 3'h3;
   localparam logic [1:0] CMD_SUBTYPE   = 2'h3;
   localparam logic [2:0] OPC_PIPE      = 3'h0;
   localparam logic [2:0] OPC_NONPIPE   = 3'h1;
   localparam logic [7:0] SUB_VS_STATE  = 8'h10;
   localparam logic [7:0] SUB_PC_PTR    = 8'h15;
   localparam logic [7:0] SUB_PC_ALLOC  = 8'h12;

   // ---------------------------------------------------------------
   // dword positions within the commands
   // ---------------------------------------------------------------
   localparam logic [8:0] VS_DW_SCRATCH = 9'h3;
   localparam logic [8:0] VS_DW_URB     = 9'h4;
   localparam logic [8:0] VS_DW_CTRL    = 9'h5;
   localparam logic [8:0] PC_DW_LEN10   = 9'h1;
   localparam logic [8:0] PC_DW_LEN32   = 9'h2;
   localparam logic [8:0] PC_DW_PTR0    = 9'h3;
   localparam logic [8:0] PC_DW_PTR1    = 9'h4;
   localparam logic [8:0] PC_DW_PTR2    = 9'h5;
   localparam logic [8:0] PC_DW_PTR3    = 9'h6;

   // ---------------------------------------------------------------
   // scratch and thread figures
   // ---------------------------------------------------------------
   localparam logic [3:0]  SCRATCH_MAX_CODE  = 4'hb;
   localparam logic [21:0] SCRATCH_MIN_BYTES = 22'h000400;
   localparam logic [7:0]  THREAD_ONE        = 8'h01;

   // ---------------------------------------------------------------
   // register offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [3:0]  REG_MODE     = 4'h0;
   localparam logic [3:0]  REG_DYN_BASE = 4'h4;
   localparam logic [3:0]  REG_INVOC    = 4'h8;
   localparam logic [3:0]  REG_STATUS   = 4'hc;
   localparam logic [31:0] RST_WORD     = 32'h00000000;

   typedef enum logic [1:0] {
      ST_HEAD = 2'b01,
      ST_BODY = 2'b10
   } vsc_state_t;

   typedef enum logic [3:0] {
      K_VS    = 4'b0001,
      K_PTR   = 4'b0010,
      K_ALLOC = 4'b0100,
      K_SKIP  = 4'b1000
   } vsc_kind_t;

endpackage

`default_nettype wire

// [vsc_thread_limit.sv]
`default_nettype none

module vsc_thread_limit #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         reset_n_in,
   // thread events
   input  wire logic         dispatch_in,
   input  wire logic         done_in,
   input  wire logic         gate_in,
   input  wire logic [W-1:0] limit_in,
   // state
   output logic      [W-1:0] count_out,
   output logic              ready_out
);

   logic [W-1:0] count_nxt;

   always_comb begin
      count_nxt = count_out;
      if (dispatch_in && !(done_in && count_out != '0)) begin
         count_nxt = count_out + {{(W-1){1'b0}}, 1'b1};
      end else if (!dispatch_in && done_in && count_out != '0) begin
         count_nxt = count_out - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_out <= '0;
         ready_out <= 1'b0;
      end else begin
         count_out <= count_nxt;
         ready_out <= !gate_in || (count_nxt < limit_in);
      end
   end

endmodule

`default_nettype wire

// [vsc_state_cmds.sv]
`default_nettype none

module vsc_state_cmds #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  reset_n_in,
   // command dword stream
   input  wire logic                  cmd_valid_in,
   input  wire logic [31:0]           cmd_dword_in,
   output logic                       cmd_done_out,
   output logic                       alloc_cmd_out,
   // draw sequencing
   input  wire logic                  draw_start_in,
   input  wire logic                  instance_start_in,
   // incoming vertices
   input  wire logic                  vertex_valid_in,
   input  wire logic                  vertex_hit_in,
   output logic                       vertex_ready_out,
   output logic                       dispatch_out,
   output logic                       reuse_out,
   output logic                       entry_write_out,
   output logic                       pass_out,
   output logic                       cache_invalidate_out,
   // thread return
   input  wire logic                  thread_done_in,
   // shading configuration
   output logic                       func_en_out,
   output logic                       cache_dis_out,
   output logic                       stats_en_out,
   output logic [3:0]                 scratch_code_out,
   output logic [21:0]                scratch_bytes_out,
   output logic [4:0]                 payload_start_out,
   output logic [5:0]                 read_len_out,
   output logic [5:0]                 read_offset_out,
   output logic [7:0]                 thread_limit_out,
   // push constants
   output logic [3:0][15:0]           cb_len_out,
   output logic [3:0]                 cb_en_out,
   output logic [3:0][26:0]           cb_ptr_out,
   output logic [4:0]                 cb_moc_out,
   // register port
   input  wire logic [3:0]            reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [31:0]                reg_rdata_out
);

   import vsc_pkg::*;

   // ---------------------------------------------------------------
   // parser state
   // ---------------------------------------------------------------
   vsc_state_t      state_r;
   vsc_kind_t       kind_r;
   vsc_kind_t       kind_nxt;
   logic [7:0]      len_r;
   logic [8:0]      idx_r;
   logic            body_w;
   logic            last_w;
   logic [31:0]     sh_scr_r;
   logic [31:0]     sh_urb_r;
   logic            vs_apply_w;
   logic            base_dis_r;
   logic [26:0]     dyn_base_r;
   logic [CNT_W-1:0] invoc_r;
   logic [7:0]      active_w;
   logic            accept_w;
   logic            need_shade_w;
   logic [3:0]      scr_code_w;

   assign body_w = (state_r == ST_BODY) && cmd_valid_in;
   assign last_w = body_w && (idx_r == ({1'b0, len_r} + 9'h001));
   assign vs_apply_w = body_w && (kind_r == K_VS) &&
                       (idx_r == VS_DW_CTRL);

   // ---------------------------------------------------------------
   // header decode
   // ---------------------------------------------------------------
   always_comb begin
      kind_nxt = K_SKIP;
      if (cmd_dword_in[31:29] == CMD_TYPE &&
          cmd_dword_in[28:27] == CMD_SUBTYPE) begin
         if (cmd_dword_in[26:24] == OPC_PIPE &&
             cmd_dword_in[23:16] == SUB_VS_STATE) begin
            kind_nxt = K_VS;
         end
         if (cmd_dword_in[26:24] == OPC_PIPE &&
             cmd_dword_in[23:16] == SUB_PC_PTR) begin
            kind_nxt = K_PTR;
         end
         if (cmd_dword_in[26:24] == OPC_NONPIPE &&
             cmd_dword_in[23:16] == SUB_PC_ALLOC) begin
            kind_nxt = K_ALLOC;
         end
      end
   end

   // ---------------------------------------------------------------
   // dword sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= ST_HEAD;
         kind_r  <= K_SKIP;
         len_r   <= 8'h00;
         idx_r   <= 9'h000;
      end else begin
         case (state_r)
            ST_HEAD: begin
               if (cmd_valid_in) begin
                  kind_r  <= kind_nxt;
                  // length from header, zero means one dword after the header
                  len_r   <= cmd_dword_in[7:0];
                  idx_r   <= 9'h001;
                  state_r <= ST_BODY;
               end
            end
            ST_BODY: begin
               if (cmd_valid_in) begin
                  idx_r <= idx_r + 9'h001;
                  if (last_w) begin
                     state_r <= ST_HEAD;
                  end
               end
            end
            default: begin
               state_r <= ST_HEAD;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cmd_done_out  <= 1'b0;
         alloc_cmd_out <= 1'b0;
      end else begin
         cmd_done_out  <= last_w && (kind_r != K_SKIP);
         alloc_cmd_out <= last_w && (kind_r == K_ALLOC);
      end
   end

   // ---------------------------------------------------------------
   // vertex stage state
   // ---------------------------------------------------------------
   // codes above the largest clamp to 2MB
   assign scr_code_w = (sh_scr_r[3:0] > SCRATCH_MAX_CODE) ?
                       SCRATCH_MAX_CODE : sh_scr_r[3:0];

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sh_scr_r <= RST_WORD;
         sh_urb_r <= RST_WORD;
      end else if (body_w && kind_r == K_VS) begin
         // reserved bits are carried but never read
         if (idx_r == VS_DW_SCRATCH) begin
            sh_scr_r <= cmd_dword_in;
         end
         if (idx_r == VS_DW_URB) begin
            sh_urb_r <= cmd_dword_in;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         func_en_out       <= 1'b0;
         cache_dis_out     <= 1'b0;
         stats_en_out      <= 1'b0;
         scratch_code_out  <= 4'h0;
         scratch_bytes_out <= SCRATCH_MIN_BYTES;
         payload_start_out <= 5'h00;
         read_len_out      <= 6'h00;
         read_offset_out   <= 6'h00;
         thread_limit_out  <= THREAD_ONE;
      end else if (vs_apply_w) begin
         func_en_out   <= cmd_dword_in[0];
         cache_dis_out <= cmd_dword_in[1];
         // statistics enable, used in every mode
         stats_en_out  <= cmd_dword_in[10];
         // shading fields only taken while enabled
         if (cmd_dword_in[0]) begin
            // code handed on to the kernel payload
            scratch_code_out  <= scr_code_w;
            scratch_bytes_out <= SCRATCH_MIN_BYTES << scr_code_w;
            payload_start_out <= sh_urb_r[24:20];
            read_len_out      <= sh_urb_r[16:11];
            read_offset_out   <= sh_urb_r[9:4];
            thread_limit_out  <= {1'b0, cmd_dword_in[31:25]} +
                                 THREAD_ONE;
         end else begin
            scratch_code_out  <= 4'h0;
            scratch_bytes_out <= SCRATCH_MIN_BYTES;
            payload_start_out <= 5'h00;
            read_len_out      <= 6'h00;
            read_offset_out   <= 6'h00;
            thread_limit_out  <= THREAD_ONE;
         end
      end
   end

   // ---------------------------------------------------------------
   // cache invalidation
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cache_invalidate_out <= 1'b0;
      end else begin
         // disable edge, enable toggle, draw, instance
         cache_invalidate_out <=
            (vs_apply_w && cmd_dword_in[1] && !cache_dis_out) ||
            (vs_apply_w && (cmd_dword_in[0] != func_en_out)) ||
            draw_start_in || instance_start_in;
      end
   end

   // ---------------------------------------------------------------
   // push constant pointers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cb_len_out <= '0;
         cb_ptr_out <= '0;
         cb_moc_out <= 5'h00;
      end else if (body_w && kind_r == K_PTR) begin
         case (idx_r)
            PC_DW_LEN10: begin
               cb_len_out[1] <= cmd_dword_in[31:16];
               cb_len_out[0] <= cmd_dword_in[15:0];
            end
            // buffer 3 high half, buffer 2 low half
            PC_DW_LEN32: begin
               cb_len_out[3] <= cmd_dword_in[31:16];
               cb_len_out[2] <= cmd_dword_in[15:0];
            end
            // buffer 0 offset by dynamic base
            PC_DW_PTR0: begin
               cb_ptr_out[0] <= base_dis_r ? cmd_dword_in[31:5] :
                                cmd_dword_in[31:5] + dyn_base_r;
               cb_moc_out    <= cmd_dword_in[4:0];
            end
            PC_DW_PTR1: begin
               cb_ptr_out[1] <= cmd_dword_in[31:5];
            end
            PC_DW_PTR2: begin
               cb_ptr_out[2] <= cmd_dword_in[31:5];
            end
            PC_DW_PTR3: begin
               cb_ptr_out[3] <= cmd_dword_in[31:5];
            end
            default: ;
         endcase
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_cb_en
      always_ff @(posedge mclk_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            cb_en_out[g] <= 1'b0;
         end else begin
            cb_en_out[g] <= |cb_len_out[g];
         end
      end
   end

   // ---------------------------------------------------------------
   // vertex routing
   // ---------------------------------------------------------------
   assign accept_w     = vertex_valid_in && vertex_ready_out;
   assign need_shade_w = func_en_out && (cache_dis_out || !vertex_hit_in);

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dispatch_out    <= 1'b0;
         reuse_out       <= 1'b0;
         entry_write_out <= 1'b0;
         pass_out        <= 1'b0;
      end else begin
         dispatch_out    <= accept_w && need_shade_w;
         reuse_out       <= accept_w && !cache_dis_out && vertex_hit_in;
         // unshaded misses go to the entry buffer
         entry_write_out <= accept_w && !func_en_out &&
                            (cache_dis_out || !vertex_hit_in);
         pass_out        <= accept_w && !func_en_out;
      end
   end

   vsc_thread_limit #(
      .W (8)
   ) vsc_thread_limit_inst (
      .mclk_in     (mclk_in),
      .reset_n_in  (reset_n_in),
      .dispatch_in (accept_w && need_shade_w),
      .done_in     (thread_done_in),
      .gate_in     (func_en_out),
      .limit_in    (thread_limit_out),
      .count_out   (active_w),
      .ready_out   (vertex_ready_out)
   );

   // ---------------------------------------------------------------
   // statistics
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         invoc_r <= '0;
      end else if (accept_w && stats_en_out) begin
         // every vertex counts, shading on or off
         invoc_r <= invoc_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         base_dis_r <= 1'b0;
         dyn_base_r <= 27'h0000000;
      end else if (reg_wr_in) begin
         if (reg_addr_in == REG_MODE) begin
            base_dis_r <= reg_wdata_in[0];
         end
         if (reg_addr_in == REG_DYN_BASE) begin
            dyn_base_r <= reg_wdata_in[31:5];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= RST_WORD;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            REG_MODE:     reg_rdata_out <= {31'h0, base_dis_r};
            REG_DYN_BASE: reg_rdata_out <= {dyn_base_r, 5'h00};
            REG_INVOC:    reg_rdata_out <= 32'(invoc_r);
            REG_STATUS:   reg_rdata_out <= {16'h0000, active_w, 5'h00,
                                 stats_en_out, cache_dis_out, func_en_out};
            default:      reg_rdata_out <= RST_WORD;
         endcase
      end else begin
         reg_rdata_out <= RST_WORD;
      end
   end

endmodule

`default_nettype wire

// [vsc_pkg_unused_guard.sv]
`default_nettype none
`default_nettype wire

// [vsc_state_cmds_props.sv]
`default_nettype none
module vsc_state_cmds_props (
   // clock and reset
   input wire logic             mclk_in,
   input wire logic             reset_n_in,
   // vertex side
   input wire logic             draw_start_in,
   input wire logic             vertex_valid_in,
   input wire logic             vertex_hit_in,
   input wire logic             vertex_ready_out,
   input wire logic             dispatch_out,
   input wire logic             reuse_out,
   input wire logic             entry_write_out,
   input wire logic             pass_out,
   input wire logic             cache_invalidate_out,
   // configuration
   input wire logic             cmd_done_out,
   input wire logic             alloc_cmd_out,
   input wire logic             func_en_out,
   input wire logic             cache_dis_out,
   input wire logic [3:0]       scratch_code_out,
   input wire logic [21:0]      scratch_bytes_out,
   input wire logic [4:0]       payload_start_out,
   input wire logic [5:0]       read_len_out,
   input wire logic [7:0]       thread_limit_out,
   input wire logic [3:0][15:0] cb_len_out,
   input wire logic [3:0]       cb_en_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   // --------------------
   // vertex routing
   // --------------------
   sequence s_take;
      vertex_valid_in && vertex_ready_out;
   endsequence
   property p_dispatch;
      s_take ##0 (func_en_out && (cache_dis_out || !vertex_hit_in))
         |=> dispatch_out && !reuse_out;
   endproperty
   a_dispatch: assert property (p_dispatch)
      else $error("shaded vertex not dispatched");
   property p_reuse;
      s_take ##0 (!cache_dis_out && vertex_hit_in)
         |=> reuse_out && !dispatch_out && !entry_write_out;
   endproperty
   a_reuse: assert property (p_reuse)
      else $error("cache hit not reused");
   property p_unshaded;
      s_take ##0 !func_en_out |=> pass_out && !dispatch_out
         && entry_write_out == $past(cache_dis_out || !vertex_hit_in);
   endproperty
   a_unshaded: assert property (p_unshaded)
      else $error("unshaded vertex routed wrongly");
   property p_stall;
      $fell(vertex_ready_out) |-> func_en_out;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall while shading off");

   // --------------------
   // cache invalidation
   // --------------------
   property p_inv_draw;
      draw_start_in |=> cache_invalidate_out;
   endproperty
   a_inv_draw: assert property (p_inv_draw)
      else $error("no invalidate at draw");
   property p_inv_mode;
      $changed(func_en_out) || $rose(cache_dis_out)
         |-> cache_invalidate_out;
   endproperty
   a_inv_mode: assert property (p_inv_mode)
      else $error("no invalidate at mode change");

   // --------------------
   // state fields
   // --------------------
   property p_scratch;
      scratch_code_out <= 4'hb
         && scratch_bytes_out == (22'h000400 << scratch_code_out);
   endproperty
   a_scratch: assert property (p_scratch)
      else $error("scratch size wrong");
   property p_limit;
      thread_limit_out inside {[8'h01:8'h80]};
   endproperty
   a_limit: assert property (p_limit)
      else $error("thread limit out of range");
   property p_off;
      !func_en_out |-> payload_start_out == 5'h00
         && read_len_out == 6'h00 && thread_limit_out == 8'h01;
   endproperty
   a_off: assert property (p_off)
      else $error("shading fields used while off");
   property p_cb_en;
      cb_en_out[0] == ($past(cb_len_out[0]) != 16'h0000)
         && cb_en_out[3] == ($past(cb_len_out[3]) != 16'h0000);
   endproperty
   a_cb_en: assert property (p_cb_en)
      else $error("buffer enable mismatch");
   property p_alloc;
      alloc_cmd_out |-> cmd_done_out;
   endproperty
   a_alloc: assert property (p_alloc)
      else $error("allocation not completed");
endmodule
`default_nettype wire

// [vsc_cmd_source.sv]
`default_nettype none
module vsc_cmd_source (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   // command dword stream
   output logic             cmd_valid_out,
   output logic [31:0]      cmd_dword_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] q[$];

   task automatic push(input logic [31:0] w);
      q.push_back(w);
   endtask

   // dwords sent whole, in given order
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cmd_valid_out <= 1'h0;
         cmd_dword_out <= 32'h00000000;
      end else if (q.size() > 0) begin
         cmd_valid_out <= 1'h1;
         cmd_dword_out <= q.pop_front();
      end else begin
         // idle: data not held
         cmd_valid_out <= 1'h0;
         cmd_dword_out <= ~cmd_dword_out;
      end
   end
endmodule
`default_nettype wire

// [tb_vsc_state_cmds.sv]
`default_nettype none
module tb_vsc_state_cmds import vsc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in, reset_n_in, cmd_valid_in, draw_start_in;
   logic instance_start_in, vertex_valid_in, vertex_hit_in;
   logic thread_done_in, reg_wr_in, reg_rd_in, cmd_done_out;
   logic alloc_cmd_out, vertex_ready_out, dispatch_out, reuse_out;
   logic entry_write_out, pass_out, cache_invalidate_out;
   logic func_en_out, cache_dis_out, stats_en_out;
   logic [31:0]       cmd_dword_in, reg_wdata_in, reg_rdata_out, rd_v;
   logic [3:0]        reg_addr_in, scratch_code_out, cb_en_out;
   logic [21:0]       scratch_bytes_out;
   logic [4:0]        payload_start_out, cb_moc_out;
   logic [5:0]        read_len_out, read_offset_out;
   logic [7:0]        thread_limit_out;
   logic [3:0][15:0]  cb_len_out;
   logic [3:0][26:0]  cb_ptr_out;
   int n_fail = 0, n_tests = 0, cyc = 0, nw = 0, n_disp = 0, n_alloc = 0;
   int n_reuse = 0, n_entry = 0, n_pass = 0, n_inv = 0, n_done = 0;

   vsc_state_cmds vsc_state_cmds_inst (.*);
   vsc_cmd_source vsc_cmd_source_inst (.mclk_in, .reset_n_in,
      .cmd_valid_out(cmd_valid_in), .cmd_dword_out(cmd_dword_in));

   // --------------------
   // clock, pulse counters, timeout
   // --------------------
   initial begin
      mclk_in = 1'h0;
      forever #10 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      n_disp += dispatch_out;
      n_reuse += reuse_out;
      n_entry += entry_write_out;
      n_pass += pass_out;
      n_inv += cache_invalidate_out;
      n_done += cmd_done_out;
      n_alloc += alloc_cmd_out;
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         conclude();
      end
   end

   // --------------------
   // tasks
   // --------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1'h1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_in);
      reg_rd_in <= 1'h1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'h0;
      #1 rd_v = reg_rdata_out;
   endtask
   task automatic put(input logic [31:0] w);
      vsc_cmd_source_inst.push(w);
      nw++;
   endtask
   task automatic go;
      repeat (nw + 4) @(posedge mclk_in);
      #1 nw = 0;
   endtask
   task automatic vs(input logic [3:0] s, input logic [4:0] g,
      input logic [5:0] l, o, input logic [6:0] m, input logic t, c, e);
      put(32'h78100004);
      put(32'h00000000);
      put(32'h00000000);
      put({28'h0000000, s});
      put({7'h00, g, 3'h0, l, 1'h0, o, 4'h0});
      put({m, 14'h0000, t, 8'h00, c, e});
      go();
   endtask
   task automatic ptr(input logic [31:0] p0);
      put(32'h78150005);
      // sum 7, unused pointer zero, linear memory
      put(32'h00020004);
      put(32'h00010000);
      put(p0);
      put(32'h00000100);
      put(32'h00000000);
      put(32'h00000200);
      go();
   endtask
   task automatic vtx(input logic h);
      int k;
      k = 0;
      @(posedge mclk_in);
      vertex_valid_in <= 1'h1;
      vertex_hit_in <= h;
      @(posedge mclk_in);
      while (vertex_ready_out !== 1'h1 && k < 50) begin
         @(posedge mclk_in);
         k++;
      end
      vertex_valid_in <= 1'h0;
   endtask
   task automatic settle;
      repeat (2) @(posedge mclk_in);
      #1;
   endtask

   // --------------------
   // main sequence
   // --------------------
   initial begin
      {reset_n_in, draw_start_in, instance_start_in} = 3'h0;
      {vertex_valid_in, vertex_hit_in, thread_done_in} = 3'h0;
      {reg_wr_in, reg_rd_in, reg_addr_in} = 6'h00;
      reg_wdata_in = 32'h00000000;
      repeat (3) @(posedge mclk_in);
      reset_n_in <= 1'h1;
      settle();
      chk("scr_bytes", 32'(scratch_bytes_out), 32'h400);
      chk("thr_lim", 32'(thread_limit_out), 32'h1);
      vs(4'hb, 5'h03, 6'h02, 6'h07, 7'h03, 1'h1, 1'h0, 1'h1);
      chk("scr_bytes", 32'(scratch_bytes_out), 32'h200000);
      chk("scr_code", 32'(scratch_code_out), 32'hb);
      chk("grf", 32'(payload_start_out), 32'h3);
      chk("rd_len", 32'(read_len_out), 32'h2);
      chk("rd_off", 32'(read_offset_out), 32'h7);
      chk("thr_lim", 32'(thread_limit_out), 32'h4);
      chk("stats", 32'(stats_en_out), 32'h1);
      chk("inval", n_inv, 1);
      vtx(1'h0);
      vtx(1'h1);
      repeat (3) vtx(1'h0);
      settle();
      chk("disp", n_disp, 4);
      chk("reuse", n_reuse, 1);
      chk("ready", 32'(vertex_ready_out), 32'h0);
      rd(REG_STATUS);
      chk("status", rd_v, 32'h405);
      repeat (4) begin
         @(posedge mclk_in);
         thread_done_in <= 1'h1;
         @(posedge mclk_in);
         thread_done_in <= 1'h0;
      end
      settle();
      chk("ready", 32'(vertex_ready_out), 32'h1);
      rd(REG_INVOC);
      chk("invoc", rd_v, 5);
      vs(4'h5, 5'h1f, 6'h3f, 6'h3f, 7'h7f, 1'h1, 1'h0, 1'h0);
      chk("scr_bytes", 32'(scratch_bytes_out), 32'h400);
      chk("grf", 32'(payload_start_out), 32'h0);
      chk("thr_lim", 32'(thread_limit_out), 32'h1);
      chk("inval", n_inv, 2);
      vtx(1'h0);
      vtx(1'h1);
      settle();
      chk("disp", n_disp, 4);
      chk("entry", n_entry, 1);
      chk("reuse", n_reuse, 2);
      chk("pass", n_pass, 2);
      rd(REG_INVOC);
      chk("invoc", rd_v, 7);
      vs(4'h0, 5'h00, 6'h01, 6'h00, 7'h00, 1'h0, 1'h1, 1'h1);
      chk("inval", n_inv, 3);
      vtx(1'h1);
      settle();
      chk("disp", n_disp, 5);
      rd(REG_INVOC);
      chk("invoc", rd_v, 7);
      rd(REG_STATUS);
      chk("status", rd_v, 32'h103);
      @(posedge mclk_in);
      draw_start_in <= 1'h1;
      @(posedge mclk_in);
      draw_start_in <= 1'h0;
      instance_start_in <= 1'h1;
      @(posedge mclk_in);
      instance_start_in <= 1'h0;
      settle();
      chk("inval", n_inv, 5);
      wr(REG_DYN_BASE, 32'h00001000);
      wr(REG_INVOC, 32'h0000ffff);
      rd(REG_DYN_BASE);
      chk("dyn_base", rd_v, 32'h1000);
      rd(REG_INVOC);
      chk("invoc_ro", rd_v, 7);
      rd(4'h2);
      chk("unmapped", rd_v, 0);
      // unknown command: body skipped by its length
      put(32'h78110001);
      repeat (2) put(32'h00000000);
      // allocation in buffer, then pointers after the draw
      put(32'h79120000);
      put(32'h00000001);
      go();
      chk("done", n_done, 4);
      chk("alloc", n_alloc, 1);
      ptr(32'h0000004a);
      chk("done", n_done, 5);
      chk("len0", 32'(cb_len_out[0]), 32'h4);
      chk("len1", 32'(cb_len_out[1]), 32'h2);
      chk("len3", 32'(cb_len_out[3]), 32'h1);
      chk("cb_en", 32'(cb_en_out), 32'hb);
      chk("ptr0", 32'(cb_ptr_out[0]), 32'h82);
      chk("ptr1", 32'(cb_ptr_out[1]), 32'h8);
      chk("ptr3", 32'(cb_ptr_out[3]), 32'h10);
      chk("moc", 32'(cb_moc_out), 32'ha);
      wr(REG_MODE, 32'h00000001);
      ptr(32'h0000004a);
      chk("ptr0", 32'(cb_ptr_out[0]), 32'h2);
      conclude();
   end
endmodule

bind vsc_state_cmds vsc_state_cmds_props vsc_state_cmds_props_inst (.*);
`default_nettype wire
